// ---- rtl/amcsr_pkg.sv ----
package amcsr_pkg;
   // register offsets on the control bus
   localparam logic [7:0] OFS_ANALOG_GAIN = 8'h54;
   localparam logic [7:0] OFS_AUX_DIR = 8'h60;
   localparam logic [7:0] OFS_AUX_SEL = 8'h61;
   localparam logic [7:0] OFS_PROC_MISC = 8'h66;
   localparam logic [7:0] OFS_CHIP_ID = 8'h67;
   localparam logic [7:0] OFS_OP_STATE = 8'h68;
   localparam logic [7:0] OFS_SILENCE_STAT = 8'h69;
   localparam logic [7:0] OFS_PHASE_CTRL = 8'h6a;

   // reset values
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [4:0] RST_GAIN = 5'h00;
   localparam logic [4:0] RST_AUX_SEL = 5'h00;
   localparam logic [1:0] RST_PHASE_OFS = 2'h0;
   localparam logic [1:0] RST_OP_STATE = 2'h0;

   // field positions
   localparam int GAIN_MSB = 4;
   localparam int AUX_DIR_BIT = 0;
   localparam int AUX_SEL_MSB = 4;
   localparam int TRACK_EN_BIT = 5;
   localparam int PHASE_OFS_LSB = 2;
   localparam int PHASE_OFS_MSB = 3;
   localparam int PHASE_SYNC_BIT = 0;
   localparam int CH1_MUTE_BIT = 0;
   localparam int CH2_MUTE_BIT = 1;

   // auxiliary pin source codes
   typedef enum logic [4:0] {
      AUX_OFF = 5'b00000,
      AUX_BOTH_MUTED = 5'b00011,
      AUX_LEFT_MUTED = 5'b00100,
      AUX_RIGHT_MUTED = 5'b00101,
      AUX_CLK_INVALID = 5'b00110,
      AUX_PLL_LOCK = 5'b00111,
      AUX_WARNING = 5'b01000,
      AUX_SERIAL_OUT = 5'b01001,
      AUX_FAULT_LOW = 5'b01011
   } amcsr_aux_src_e;

   // operating states
   typedef enum logic [1:0] {
      OPST_DEEP_SLEEP = 2'b00,
      OPST_SLEEP = 2'b01,
      OPST_HIZ = 2'b10,
      OPST_PLAY = 2'b11
   } amcsr_op_state_e;
endpackage

// ---- rtl/amcsr_sync2.sv ----
`timescale 1ns/1ps
module amcsr_sync2 #(
   parameter int WIDTH = 1
) (
   // clock and control
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   // data
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] meta_q;

   // first stage feeds only the second stage
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         meta_q <= '0;
         o_sync <= '0;
      end else if (i_clk_en) begin
         meta_q <= i_async;
         o_sync <= meta_q;
      end
   end
endmodule // amcsr_sync2

// ---- rtl/amcsr_aux_mux.sv ----
`timescale 1ns/1ps
module amcsr_aux_mux (
   // clock and control
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   // selection
   input wire logic i_dir_out,
   input wire logic [4:0] i_sel,
   // sources
   input wire logic i_chan1_silence_muted,
   input wire logic i_chan2_silence_muted,
   input wire logic i_clk_invalid,
   input wire logic i_pll_lock,
   input wire logic i_warning,
   input wire logic i_serial_audio_out,
   input wire logic i_fault_out_low,
   // pin drive
   output logic o_pin_out,
   output logic o_pin_oe_b
);
   logic pin_d;

   always_comb begin
      case (i_sel)
         amcsr_pkg::AUX_OFF: pin_d = 1'b0;
         amcsr_pkg::AUX_BOTH_MUTED: pin_d = i_chan1_silence_muted & i_chan2_silence_muted;
         amcsr_pkg::AUX_LEFT_MUTED: pin_d = i_chan1_silence_muted;
         amcsr_pkg::AUX_RIGHT_MUTED: pin_d = i_chan2_silence_muted;
         amcsr_pkg::AUX_CLK_INVALID: pin_d = i_clk_invalid;
         amcsr_pkg::AUX_PLL_LOCK: pin_d = i_pll_lock;
         amcsr_pkg::AUX_WARNING: pin_d = i_warning;
         amcsr_pkg::AUX_SERIAL_OUT: pin_d = i_serial_audio_out;
         amcsr_pkg::AUX_FAULT_LOW: pin_d = i_fault_out_low;
         default: pin_d = 1'b0;
      endcase
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_pin_out <= 1'b0;
         o_pin_oe_b <= 1'b1;
      end else if (i_clk_en) begin
         o_pin_out <= pin_d;
         o_pin_oe_b <= ~i_dir_out;
      end
   end
endmodule // amcsr_aux_mux

// ---- rtl/amcsr_regs.sv ----
`timescale 1ns/1ps
// Behaviour
// - five-bit gain, 0 dB down in 0.5 dB
// - direction bit: 0 input, 1 driven output
// - source code zero drives pin low
// - codes 3,4,5 route mute flags
// - codes 6,7,8 route clock, lock, warning
// - code 9 serial out, 11 fault low
// - misc bit 5 enables supply tracking
// - read-only chip identifier, writes ignored
// - two-bit operating state readback
// - status bit 1 is channel 2 muted
// - status bit 0 is channel 1 muted
// - bits 3-2 pick 45 degree phase steps
// - phase control bit 0 enables sync
// - sync aligns pwm to audio timing
// - mute only after programmed zero run
// - joint mode mutes only both together
module amcsr_regs #(
   parameter logic [7:0] CHIP_ID = 8'h5c // arbitrary value
) (
   // clock and control
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   // register port from the control bus engine
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // device status from core logic
   input wire logic [1:0] i_operating_state_field,
   input wire logic i_chan1_zero_run_done,
   input wire logic i_chan2_zero_run_done,
   input wire logic i_joint_silence_mute_mode,
   input wire logic i_clk_invalid,
   input wire logic i_pll_lock,
   input wire logic i_warning,
   input wire logic i_serial_audio_out,
   input wire logic i_fault_out_low,
   // pins from outside
   input wire logic i_aux_pin_in,
   input wire logic i_audio_frame_sync,
   // auxiliary pin drive
   output logic o_aux_pin_out,
   output logic o_aux_pin_oe_b,
   output logic o_aux_pin_level,
   // controls to the core
   output logic [4:0] o_analog_gain_field,
   output logic o_supply_tracking_en,
   output logic [1:0] o_switching_phase_offset,
   output logic o_phase_sync_en,
   output logic o_ramp_sync_pulse,
   output logic o_chan1_silence_muted,
   output logic o_chan2_silence_muted
);
   logic [4:0] gain_q;
   logic aux_dir_q;
   logic [4:0] aux_sel_q;
   logic track_en_q;
   logic [1:0] phase_ofs_q;
   logic phase_sync_q;
   logic chan1_muted_q;
   logic chan2_muted_q;
   logic chan1_muted_d;
   logic chan2_muted_d;
   logic [7:0] rdata_d;
   logic frame_sync_s;
   logic frame_sync_prev_q;
   logic aux_pin_s;
   logic in_play;
   logic wr_gain;
   logic wr_dir;
   logic wr_sel;
   logic wr_misc;
   logic wr_phase;

   assign in_play = (i_operating_state_field == amcsr_pkg::OPST_PLAY);
   assign wr_gain = i_reg_wr && (i_reg_addr == amcsr_pkg::OFS_ANALOG_GAIN);
   assign wr_dir = i_reg_wr && (i_reg_addr == amcsr_pkg::OFS_AUX_DIR);
   assign wr_sel = i_reg_wr && (i_reg_addr == amcsr_pkg::OFS_AUX_SEL);
   assign wr_misc = i_reg_wr && (i_reg_addr == amcsr_pkg::OFS_PROC_MISC);
   assign wr_phase = i_reg_wr && (i_reg_addr == amcsr_pkg::OFS_PHASE_CTRL);

   // pins arrive from outside the clock domain
   amcsr_sync2 #(
      .WIDTH(2)
   ) u_pin_sync (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_async({i_audio_frame_sync, i_aux_pin_in}),
      .o_sync({frame_sync_s, aux_pin_s})
   );

   // analog gain, each code step is a further half decibel down
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         gain_q <= amcsr_pkg::RST_GAIN;
      end else if (i_clk_en && wr_gain) begin
         gain_q <= i_reg_wdata[amcsr_pkg::GAIN_MSB:0];
      end
   end

   // auxiliary pin direction and source
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         aux_dir_q <= 1'b0;
         aux_sel_q <= amcsr_pkg::RST_AUX_SEL;
      end else if (i_clk_en) begin
         if (wr_dir) begin
            aux_dir_q <= i_reg_wdata[amcsr_pkg::AUX_DIR_BIT];
         end
         if (wr_sel) begin
            aux_sel_q <= i_reg_wdata[amcsr_pkg::AUX_SEL_MSB:0];
         end
      end
   end

   // supply tracking enable
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         track_en_q <= 1'b0;
      end else if (i_clk_en && wr_misc) begin
         track_en_q <= i_reg_wdata[amcsr_pkg::TRACK_EN_BIT];
      end
   end

   // switching phase control
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         phase_ofs_q <= amcsr_pkg::RST_PHASE_OFS;
         phase_sync_q <= 1'b0;
      end else if (i_clk_en && wr_phase) begin
         phase_ofs_q <= i_reg_wdata[amcsr_pkg::PHASE_OFS_MSB:amcsr_pkg::PHASE_OFS_LSB];
         phase_sync_q <= i_reg_wdata[amcsr_pkg::PHASE_SYNC_BIT];
      end
   end

   // phase offset reaches the ramp only outside play, so a late write cannot
   // step the ramp mid-stream; it takes effect as soon as the state leaves play
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_switching_phase_offset <= amcsr_pkg::RST_PHASE_OFS;
      end else if (i_clk_en && !in_play) begin
         o_switching_phase_offset <= phase_ofs_q;
      end
   end

   // pwm alignment pulse on each rising audio frame edge while sync is enabled
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         frame_sync_prev_q <= 1'b0;
         o_ramp_sync_pulse <= 1'b0;
      end else if (i_clk_en) begin
         frame_sync_prev_q <= frame_sync_s;
         o_ramp_sync_pulse <= phase_sync_q && frame_sync_s && !frame_sync_prev_q;
      end
   end

   // mute status follows the zero-run detectors
   always_comb begin
      if (i_joint_silence_mute_mode) begin
         chan1_muted_d = i_chan1_zero_run_done && i_chan2_zero_run_done;
         chan2_muted_d = i_chan1_zero_run_done && i_chan2_zero_run_done;
      end else begin
         chan1_muted_d = i_chan1_zero_run_done;
         chan2_muted_d = i_chan2_zero_run_done;
      end
   end

   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         chan1_muted_q <= 1'b0;
         chan2_muted_q <= 1'b0;
      end else if (i_clk_en) begin
         chan1_muted_q <= chan1_muted_d;
         chan2_muted_q <= chan2_muted_d;
      end
   end

   // outputs to the core, all from flops
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_analog_gain_field <= amcsr_pkg::RST_GAIN;
         o_supply_tracking_en <= 1'b0;
         o_phase_sync_en <= 1'b0;
         o_chan1_silence_muted <= 1'b0;
         o_chan2_silence_muted <= 1'b0;
         o_aux_pin_level <= 1'b0;
      end else if (i_clk_en) begin
         o_analog_gain_field <= gain_q;
         o_supply_tracking_en <= track_en_q;
         o_phase_sync_en <= phase_sync_q;
         o_chan1_silence_muted <= chan1_muted_q;
         o_chan2_silence_muted <= chan2_muted_q;
         o_aux_pin_level <= aux_pin_s;
      end
   end

   amcsr_aux_mux u_aux_mux (
      .i_mclk(i_mclk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_dir_out(aux_dir_q),
      .i_sel(aux_sel_q),
      .i_chan1_silence_muted(chan1_muted_q),
      .i_chan2_silence_muted(chan2_muted_q),
      .i_clk_invalid(i_clk_invalid),
      .i_pll_lock(i_pll_lock),
      .i_warning(i_warning),
      .i_serial_audio_out(i_serial_audio_out),
      .i_fault_out_low(i_fault_out_low),
      .o_pin_out(o_aux_pin_out),
      .o_pin_oe_b(o_aux_pin_oe_b)
   );

   // read mux; unmapped offsets and reserved bits read zero
   always_comb begin
      rdata_d = amcsr_pkg::RST_ZERO;
      case (i_reg_addr)
         amcsr_pkg::OFS_ANALOG_GAIN: rdata_d[amcsr_pkg::GAIN_MSB:0] = gain_q;
         amcsr_pkg::OFS_AUX_DIR: rdata_d[amcsr_pkg::AUX_DIR_BIT] = aux_dir_q;
         amcsr_pkg::OFS_AUX_SEL: rdata_d[amcsr_pkg::AUX_SEL_MSB:0] = aux_sel_q;
         amcsr_pkg::OFS_PROC_MISC: rdata_d[amcsr_pkg::TRACK_EN_BIT] = track_en_q;
         amcsr_pkg::OFS_CHIP_ID: rdata_d = CHIP_ID;
         amcsr_pkg::OFS_OP_STATE: rdata_d[1:0] = i_operating_state_field;
         amcsr_pkg::OFS_SILENCE_STAT: begin
            rdata_d[amcsr_pkg::CH1_MUTE_BIT] = chan1_muted_q;
            rdata_d[amcsr_pkg::CH2_MUTE_BIT] = chan2_muted_q;
         end
         amcsr_pkg::OFS_PHASE_CTRL: begin
            rdata_d[amcsr_pkg::PHASE_OFS_MSB:amcsr_pkg::PHASE_OFS_LSB] = phase_ofs_q;
            rdata_d[amcsr_pkg::PHASE_SYNC_BIT] = phase_sync_q;
         end
         default: rdata_d = amcsr_pkg::RST_ZERO;
      endcase
   end

   // read data holds until the next read
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         o_reg_rdata <= amcsr_pkg::RST_ZERO;
         o_reg_rvalid <= 1'b0;
      end else if (i_clk_en) begin
         o_reg_rvalid <= i_reg_rd;
         if (i_reg_rd) begin
            o_reg_rdata <= rdata_d;
         end
      end
   end
endmodule // amcsr_regs

// ---- sim/amcsr_host.sv ----
`timescale 1ns/1ps
module amcsr_host (
   // clock and answer
   input wire logic i_mclk,
   input wire logic [7:0] i_reg_rdata,
   input wire logic i_reg_rvalid,
   // request
   output logic [7:0] o_reg_addr,
   output logic [7:0] o_reg_wdata,
   output logic o_reg_wr,
   output logic o_reg_rd
);
   initial begin
      o_reg_addr = 8'h00;
      o_reg_wdata = 8'h00;
      o_reg_wr = 1'b0;
      o_reg_rd = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge i_mclk);
      o_reg_addr = a;
      o_reg_wdata = d;
      o_reg_wr = 1'b1;
      @(negedge i_mclk);
      o_reg_wr = 1'b0;
      // stale data must not pass for a held value
      o_reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
      @(negedge i_mclk);
      o_reg_addr = a;
      o_reg_rd = 1'b1;
      @(negedge i_mclk);
      o_reg_rd = 1'b0;
      ok = 1'b0;
      for (int n = 0; n < 4 && !ok; n++) begin
         if (n > 0)
            @(negedge i_mclk);
         ok = i_reg_rvalid === 1'b1;
         d = i_reg_rdata;
      end
   endtask
endmodule // amcsr_host

// ---- sim/amcsr_regs_assertions.sv ----
`timescale 1ns/1ps
module amcsr_regs_checker #(
   parameter logic [7:0] CHIP_ID = 8'h5c // arbitrary value
) (
   // clock and bus
   input wire logic i_mclk,
   input wire logic i_rst_b,
   input wire logic i_clk_en,
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   // status and pins
   input wire logic i_chan1_zero_run_done,
   input wire logic i_chan2_zero_run_done,
   input wire logic i_joint_silence_mute_mode,
   input wire logic i_audio_frame_sync,
   input wire logic o_aux_pin_out,
   input wire logic o_aux_pin_oe_b,
   input wire logic [4:0] o_analog_gain_field,
   input wire logic o_supply_tracking_en,
   input wire logic o_phase_sync_en,
   input wire logic o_ramp_sync_pulse
);
   logic dir_q;
   logic [4:0] sel_q;
   logic [2:0] mv;
   logic [1:0] mexp;
   assign mv = {i_joint_silence_mute_mode, i_chan2_zero_run_done, i_chan1_zero_run_done};
   assign mexp = mv[2] ? {2{mv[1] & mv[0]}} : mv[1:0];
   // copy of the pin fields; the pin itself lags them by one cycle
   always_ff @(posedge i_mclk) begin
      if (!i_rst_b) begin
         dir_q <= 1'b0;
         sel_q <= 5'h00;
      end else if (i_clk_en && i_reg_wr && i_reg_addr == amcsr_pkg::OFS_AUX_DIR) begin
         dir_q <= i_reg_wdata[0];
      end else if (i_clk_en && i_reg_wr && i_reg_addr == amcsr_pkg::OFS_AUX_SEL) begin
         sel_q <= i_reg_wdata[4:0];
      end
   end
   default clocking cb @(posedge i_mclk);
   endclocking
   default disable iff (!i_rst_b || !i_clk_en);
   a_gain_write:
      assert property (i_reg_wr && i_reg_addr == amcsr_pkg::OFS_ANALOG_GAIN
         |-> ##2 o_analog_gain_field == $past(i_reg_wdata[4:0], 2)) else $error("gain mismatch");
   a_track_write:
      assert property (i_reg_wr && i_reg_addr == amcsr_pkg::OFS_PROC_MISC
         |-> ##2 o_supply_tracking_en == $past(i_reg_wdata[5], 2)) else $error("tracking mismatch");
   a_sync_en_write:
      assert property (i_reg_wr && i_reg_addr == amcsr_pkg::OFS_PHASE_CTRL
         |-> ##2 o_phase_sync_en == $past(i_reg_wdata[0], 2)) else $error("sync enable mismatch");
   a_chip_id_read:
      assert property (i_reg_rd && i_reg_addr == amcsr_pkg::OFS_CHIP_ID |=> o_reg_rdata == CHIP_ID)
         else $error("chip id mismatch");
   a_mute_readback:
      assert property (i_reg_rd && i_reg_addr == amcsr_pkg::OFS_SILENCE_STAT && $past(i_rst_b) && $stable(mv)
         |=> o_reg_rdata == {6'h00, $past(mexp)}) else $error("mute status mismatch");
   a_pin_direction:
      assert property (o_aux_pin_oe_b == !$past(dir_q)) else $error("pin direction mismatch");
   a_pin_low_codes:
      assert property ($past(sel_q) inside {5'h00, 5'h01, 5'h02, 5'h0a, [5'h0c:5'h1f]} |-> !o_aux_pin_out)
         else $error("pin not low");
   a_frame_pulse:
      assert property ($rose(i_audio_frame_sync) && o_phase_sync_en |-> ##3 o_ramp_sync_pulse ##1 !o_ramp_sync_pulse)
         else $error("sync pulse mismatch");
endmodule // amcsr_regs_checker
bind amcsr_regs amcsr_regs_checker #(.CHIP_ID(CHIP_ID)) u_amcsr_regs_checker (.*);

// ---- sim/amcsr_regs_tb.sv ----
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end
module amcsr_regs_tb;
   localparam logic [7:0] TB_CHIP_ID = 8'h3b; // arbitrary value
   localparam logic [7:0] RW_OFS [5] = '{8'h54, 8'h60, 8'h61, 8'h66, 8'h6a};
   localparam logic [7:0] RW_MSK [5] = '{8'h1f, 8'h01, 8'h1f, 8'h20, 8'h0d};
   localparam logic [7:0] RO_OFS [4] = '{8'h67, 8'h68, 8'h69, 8'h62};
   localparam logic [7:0] RO_EXP [4] = '{TB_CHIP_ID, 8'h00, 8'h00, 8'h00};
   localparam logic [4:0] CODES [13] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09,
      5'h0a, 5'h0b, 5'h1f};
   // sources that lift the pin: {fault, sout, warn, pll, clkinv, ch2, ch1}
   localparam logic [6:0] SRCS [13] = '{7'h00, 7'h00, 7'h00, 7'h03, 7'h01, 7'h02, 7'h04, 7'h08, 7'h10, 7'h20,
      7'h00, 7'h40, 7'h00};
   localparam logic [2:0] MUTE_IN [4] = '{3'h1, 3'h2, 3'h5, 3'h7};
   localparam logic [1:0] MUTE_EX [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
   logic i_mclk, i_rst_b, i_clk_en, i_reg_wr, i_reg_rd, o_reg_rvalid, i_chan1_zero_run_done, i_chan2_zero_run_done;
   logic i_joint_silence_mute_mode, i_clk_invalid, i_pll_lock, i_warning, i_serial_audio_out, i_fault_out_low;
   logic i_aux_pin_in, i_audio_frame_sync, o_aux_pin_out, o_aux_pin_oe_b, o_aux_pin_level, o_supply_tracking_en;
   logic o_phase_sync_en, o_ramp_sync_pulse, o_chan1_silence_muted, o_chan2_silence_muted;
   logic [7:0] i_reg_addr, i_reg_wdata, o_reg_rdata;
   logic [1:0] i_operating_state_field, o_switching_phase_offset;
   logic [4:0] o_analog_gain_field;
   int n_fail, n_tests;
   amcsr_regs #(.CHIP_ID(TB_CHIP_ID)) u_amcsr_regs (.*);
   amcsr_host u_amcsr_host (.i_mclk(i_mclk), .i_reg_rdata(o_reg_rdata), .i_reg_rvalid(o_reg_rvalid),
      .o_reg_addr(i_reg_addr), .o_reg_wdata(i_reg_wdata), .o_reg_wr(i_reg_wr), .o_reg_rd(i_reg_rd));
   initial begin
      i_mclk = 1'b0;
      forever #4 i_mclk = ~i_mclk;
   end
   task automatic tally_and_finish();
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic ok;
      u_amcsr_host.rd(a, d, ok);
      if (!ok) begin
         n_fail++;
         $display("ERROR read answer exp 1 got 0");
         tally_and_finish();
      end else begin
         `CHK("read data", e, d)
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(negedge i_mclk);
   endtask
   task automatic t_regs();
      for (int i = 0; i < 5; i++) begin
         rchk(RW_OFS[i], 8'h00);
         u_amcsr_host.wr(RW_OFS[i], 8'hff);
         rchk(RW_OFS[i], RW_MSK[i]);
      end
      idle(2);
      `CHK("gain", 5'h1f, o_analog_gain_field)
      `CHK("tracking", 1'b1, o_supply_tracking_en)
      `CHK("phase", 2'h3, o_switching_phase_offset)
      for (int i = 0; i < 5; i++)
         u_amcsr_host.wr(RW_OFS[i], 8'h00);
      for (int i = 0; i < 4; i++) begin
         u_amcsr_host.wr(RO_OFS[i], 8'hff);
         rchk(RO_OFS[i], RO_EXP[i]);
      end
      $display("test regs done");
   endtask
   task automatic t_aux();
      u_amcsr_host.wr(8'h60, 8'h01);
      for (int i = 0; i < 13; i++) begin
         u_amcsr_host.wr(8'h61, {3'h0, CODES[i]});
         for (int v = 0; v < 2; v++) begin
            {i_fault_out_low, i_serial_audio_out, i_warning, i_pll_lock, i_clk_invalid, i_chan2_zero_run_done,
               i_chan1_zero_run_done} = v ? ~SRCS[i] : SRCS[i];
            idle(4);
            `CHK("aux pin", v == 0 && SRCS[i] != 7'h00, o_aux_pin_out)
         end
      end
      `CHK("aux oe", 1'b0, o_aux_pin_oe_b)
      u_amcsr_host.wr(8'h60, 8'h00);
      idle(2);
      `CHK("aux oe", 1'b1, o_aux_pin_oe_b)
      // input level passes the pin synchroniser and one output flop
      i_aux_pin_in = 1'b1;
      idle(4);
      `CHK("aux level", 1'b1, o_aux_pin_level)
      i_aux_pin_in = 1'b0;
      idle(4);
      `CHK("aux level", 1'b0, o_aux_pin_level)
      $display("test aux done");
   endtask
   task automatic t_mute();
      for (int i = 0; i < 4; i++) begin
         {i_joint_silence_mute_mode, i_chan2_zero_run_done, i_chan1_zero_run_done} = MUTE_IN[i];
         idle(3);
         rchk(8'h69, {6'h00, MUTE_EX[i]});
         `CHK("mute", MUTE_EX[i], {o_chan2_silence_muted, o_chan1_silence_muted})
      end
      $display("test mute done");
   endtask
   task automatic t_state_phase();
      for (int s = 0; s < 4; s++) begin
         i_operating_state_field = s[1:0];
         idle(2);
         rchk(8'h68, {6'h00, s[1:0]});
      end
      i_operating_state_field = amcsr_pkg::OPST_HIZ;
      u_amcsr_host.wr(8'h6a, 8'h04);
      idle(2);
      `CHK("phase", 2'h1, o_switching_phase_offset)
      i_operating_state_field = amcsr_pkg::OPST_PLAY;
      u_amcsr_host.wr(8'h6a, 8'h08);
      rchk(8'h6a, 8'h08);
      `CHK("phase in play", 2'h1, o_switching_phase_offset)
      i_operating_state_field = amcsr_pkg::OPST_HIZ;
      idle(2);
      `CHK("phase", 2'h2, o_switching_phase_offset)
      $display("test state_phase done");
   endtask
   task automatic t_sync();
      int c;
      for (int e = 1; e >= 0; e--) begin
         u_amcsr_host.wr(8'h6a, {7'h00, e[0]});
         idle(2);
         c = 0;
         i_audio_frame_sync = 1'b1;
         repeat (10) begin
            @(negedge i_mclk);
            c += (o_ramp_sync_pulse === 1'b1);
         end
         i_audio_frame_sync = 1'b0;
         idle(6);
         `CHK("sync pulses", e, c)
      end
      $display("test sync done");
   endtask
   initial begin
      n_fail = 0;
      n_tests = 0;
      i_rst_b = 1'b0;
      i_clk_en = 1'b1;
      i_operating_state_field = 2'h0;
      {i_chan1_zero_run_done, i_chan2_zero_run_done, i_joint_silence_mute_mode, i_clk_invalid, i_pll_lock} = 5'h00;
      {i_warning, i_serial_audio_out, i_fault_out_low, i_aux_pin_in, i_audio_frame_sync} = 5'h00;
      repeat (16) @(negedge i_mclk);
      i_rst_b = 1'b1;
      t_regs();
      t_aux();
      t_mute();
      t_state_phase();
      t_sync();
      tally_and_finish();
   end
endmodule // amcsr_regs_tb
